// ===== prot_overlap.sv
// Overlap arbitration of a two-cell lithium-ion protection controller.
`timescale 1ns/1ps
`default_nettype none

module prot_overlap
   import prot_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ovc_cmp,
   input wire logic ovd_cmp,
   input wire logic ocr_cmp,
   input wire logic shc_cmp,
   input wire logic xch_cmp,
   input wire logic test_short,
   output logic dis_gate,
   output logic chg_gate,
   output logic pull_dn,
   output logic pull_up,
   output logic standby
);

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   // Comparators are asynchronous; a level counts once stages two and
   // three agree, so a single metastable sample cannot flip a state.
   logic [5:0] s1_r, s2_r, s3_r, q_r;
   logic [5:0] s1_nxt, s2_nxt, s3_nxt, q_nxt;
   cmp_t c;
   logic tst;

   always_comb
   begin
      s1_nxt = {test_short, ovc_cmp, ovd_cmp, ocr_cmp, shc_cmp, xch_cmp};
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      q_nxt = q_r;
      for (int i = 0; i < 6; i++)
      begin
         if (s2_r[i] == s3_r[i])
            q_nxt[i] = s3_r[i];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s1_r <= 6'h00;
         s2_r <= 6'h00;
         s3_r <= 6'h00;
         q_r <= 6'h00;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         q_r <= q_nxt;
      end
   end

   assign c = cmp_t'(q_r[4:0]);
   assign tst = q_r[5];

   // ************************************************************
   // Delay limits
   // ************************************************************
   function automatic logic [CW-1:0] lim(input int unsigned us,
                                         input logic t);
      int unsigned n;
      n = us * (CLK_HZ / 1_000_000);
      if (t)
         n = n / TEST_DIV;
      if (n < 1)
         n = 1;
      return n[CW-1:0];
   endfunction : lim

   logic [CW-1:0] ovc_lim, ovd_lim, ocr_lim, rel_lim, xch_lim, shc_lim;
   assign ovc_lim = lim(OVC_DLY_US, tst);
   assign ovd_lim = lim(OVD_DLY_US, tst);
   assign ocr_lim = lim(OCR_DLY_US, tst);
   assign rel_lim = lim(OCR_REL_US, tst);
   assign xch_lim = lim(XCH_DLY_US, tst);
   assign shc_lim = SHC_CYC[CW-1:0];

   // ************************************************************
   // Protection state
   // ************************************************************
   dstate_t st_r, st_nxt;
   logic ovc_st_r, ovc_st_nxt, xch_st_r, xch_st_nxt;
   logic [CW-1:0] ovc_cnt_r, ovd_cnt_r, ocr_cnt_r, shc_cnt_r, xch_cnt_r;
   logic [CW-1:0] ovc_cnt_nxt, ovd_cnt_nxt, ocr_cnt_nxt, shc_cnt_nxt;
   logic [CW-1:0] xch_cnt_nxt;
   logic ovd_run, ocr_run, xch_run;
   drv_t drv_r, drv_nxt;

   // A pending over-charge detection holds over-discharge at zero; once
   // the over-charge state is set, over-discharge counts again.
   assign ovd_run = c.ovd && !(c.ovc && !ovc_st_r)
                    && st_r != ST_STBY;
   assign ocr_run = c.ocr && !ovc_st_r && st_r == ST_NORM;
   assign xch_run = c.xch && st_r == ST_NORM
                    && drv_r.dis_gate;

   always_comb
   begin
      st_nxt = st_r;
      ovc_st_nxt = ovc_st_r;
      xch_st_nxt = xch_st_r;
      ovc_cnt_nxt = ZERO;
      ovd_cnt_nxt = ZERO;
      ocr_cnt_nxt = ZERO;
      shc_cnt_nxt = ZERO;
      xch_cnt_nxt = ZERO;
      // Over-charge detect and release, independent of over-current.
      if (c.ovc != ovc_st_r)
      begin
         ovc_cnt_nxt = ovc_cnt_r + ONE;
         if (ovc_cnt_r + ONE >= ovc_lim)
         begin
            ovc_st_nxt = c.ovc;
            ovc_cnt_nxt = ZERO;
         end
      end
      // Over-discharge: restarted from zero when suspended or dropped.
      if (ovd_run)
      begin
         ovd_cnt_nxt = ovd_cnt_r + ONE;
         if (ovd_cnt_r + ONE >= ovd_lim)
         begin
            st_nxt = ovc_st_r ? ST_OVD : ST_STBY;
            ovd_cnt_nxt = ZERO;
         end
      end
      case (st_r)
         ST_NORM:
         begin
            if (ocr_run)
            begin
               ocr_cnt_nxt = ocr_cnt_r + ONE;
               if (ocr_cnt_r + ONE >= ocr_lim)
                  st_nxt = ST_OCR;
            end
         end
         ST_OCR, ST_SHC:
         begin
            if (!c.ocr && !c.shc)
            begin
               ocr_cnt_nxt = ocr_cnt_r + ONE;
               if (ocr_cnt_r + ONE >= rel_lim)
                  st_nxt = ST_NORM;
            end
         end
         ST_OVD, ST_STBY:
         begin
            // Release needs only the cells back above limit, held for the over-discharge delay.
            if (!c.ovd)
            begin
               ocr_cnt_nxt = ocr_cnt_r + ONE;
               if (ocr_cnt_r + ONE >= ovd_lim)
                  st_nxt = ST_NORM;
            end
         end
         default:
            st_nxt = ST_NORM;
      endcase
      // Short circuit has a fixed analog-style delay of its own.
      if (c.shc && st_r != ST_STBY && st_r != ST_SHC)
      begin
         shc_cnt_nxt = shc_cnt_r + ONE;
         if (shc_cnt_r + ONE >= shc_lim && st_nxt != ST_STBY)
            st_nxt = ST_SHC;
      end
      // The shared counter must not carry a count into the next state.
      if (st_nxt != st_r)
         ocr_cnt_nxt = ZERO;
      // Excess charger detect; dropping early abandons it.
      if (xch_st_r)
      begin
         if (!c.xch)
         begin
            xch_cnt_nxt = xch_cnt_r + ONE;
            if (xch_cnt_r + ONE >= xch_lim)
               xch_st_nxt = 1'b0;
         end
      end
      else if (xch_run)
      begin
         xch_cnt_nxt = xch_cnt_r + ONE;
         if (xch_cnt_r + ONE >= xch_lim)
            xch_st_nxt = 1'b1;
      end
      if (xch_st_nxt != xch_st_r)
         xch_cnt_nxt = ZERO;
   end

   // ************************************************************
   // Output decode
   // ************************************************************
   always_comb
   begin
      drv_nxt.dis_gate = st_nxt == ST_NORM;
      drv_nxt.chg_gate = !ovc_st_nxt && !xch_st_nxt;
      drv_nxt.pull_dn = st_nxt == ST_OCR
                        || st_nxt == ST_SHC;
      drv_nxt.pull_up = st_nxt == ST_OVD
                        || st_nxt == ST_STBY;
      drv_nxt.standby = st_nxt == ST_STBY;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_r <= ST_NORM;
         ovc_st_r <= 1'b0;
         xch_st_r <= 1'b0;
         ovc_cnt_r <= ZERO;
         ovd_cnt_r <= ZERO;
         ocr_cnt_r <= ZERO;
         shc_cnt_r <= ZERO;
         xch_cnt_r <= ZERO;
         drv_r <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
         ovc_st_r <= ovc_st_nxt;
         xch_st_r <= xch_st_nxt;
         ovc_cnt_r <= ovc_cnt_nxt;
         ovd_cnt_r <= ovd_cnt_nxt;
         ocr_cnt_r <= ocr_cnt_nxt;
         shc_cnt_r <= shc_cnt_nxt;
         xch_cnt_r <= xch_cnt_nxt;
         drv_r <= drv_nxt;
      end
   end

   assign dis_gate = drv_r.dis_gate;
   assign chg_gate = drv_r.chg_gate;
   assign pull_dn = drv_r.pull_dn;
   assign pull_up = drv_r.pull_up;
   assign standby = drv_r.standby;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_ovc_blocks_ocr;
      (ovc_st_r && st_r == ST_NORM) |=> ocr_cnt_r == ZERO;
   endproperty
   a_ovc_blocks_ocr: assert property (p_ovc_blocks_ocr)
      else $error("Over-current ran during over-charge.");

   property p_ocr_pull;
      (st_r == ST_OCR) |-> pull_dn;
   endproperty
   a_ocr_pull: assert property (p_ocr_pull)
      else $error("Pull-down missing in over-current.");

   property p_ovc_release;
      (ovc_st_r && st_r == ST_NORM) |=> !pull_dn || st_r == ST_SHC;
   endproperty
   a_ovc_release: assert property (p_ovc_release)
      else $error("Sense node pulled during over-charge.");

   property p_ovd_suspend;
      (c.ovc && !ovc_st_r) |=> ovd_cnt_r == ZERO;
   endproperty
   a_ovd_suspend: assert property (p_ovd_suspend)
      else $error("Over-discharge counted during over-charge.");

   property p_no_stby_ovc;
      (ovc_st_r && st_r == ST_NORM) |=> !standby;
   endproperty
   a_no_stby_ovc: assert property (p_no_stby_ovc)
      else $error("Standby entered after over-charge.");

   property p_stby_pulls;
      standby |-> pull_up && !pull_dn && !dis_gate;
   endproperty
   a_stby_pulls: assert property (p_stby_pulls)
      else $error("Standby output mix wrong.");

   property p_xch_inhibit;
      !dis_gate |=> xch_cnt_r == ZERO || xch_st_r;
   endproperty
   a_xch_inhibit: assert property (p_xch_inhibit)
      else $error("Charger delay ran with gate low.");

   sequence s_xch_drop;
      !xch_st_r && xch_cnt_r != ZERO ##1 (!c.xch && !xch_st_r);
   endsequence
   property p_xch_abort;
      s_xch_drop |=> xch_cnt_r == ZERO;
   endproperty
   a_xch_abort: assert property (p_xch_abort)
      else $error("Charger delay kept after drop.");

   property p_gate_state;
      ##1 (dis_gate == (st_r == ST_NORM));
   endproperty
   a_gate_state: assert property (p_gate_state)
      else $error("Discharge gate disagrees with state.");

endmodule : prot_overlap
`default_nettype wire

// ===== prot_pkg.sv
// Constants and carrier types for the cell protection overlap logic.
package prot_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned OVC_DLY_US = 1000;
   localparam int unsigned OVD_DLY_US = 20000;
   localparam int unsigned OCR_DLY_US = 10000;
   localparam int unsigned OCR_REL_US = 1000;
   localparam int unsigned XCH_DLY_US = 10000;
   localparam int unsigned SHC_DLY_US = 300;
   localparam int unsigned TEST_DIV = 64;
   localparam int unsigned SHC_CYC = SHC_DLY_US * (CLK_HZ / 1_000_000);
   localparam int CW = 24;
   localparam logic [CW-1:0] ZERO = 24'h000000;
   localparam logic [CW-1:0] ONE = 24'h000001;

   // Comparator outputs, already qualified to one clock domain.
   typedef struct packed {
      logic ovc;
      logic ovd;
      logic ocr;
      logic shc;
      logic xch;
   } cmp_t;

   // Gate and sense-node switch outputs.
   typedef struct packed {
      logic dis_gate;
      logic chg_gate;
      logic pull_dn;
      logic pull_up;
      logic standby;
   } drv_t;

   typedef enum logic [4:0] {
      ST_NORM = 5'h01,
      ST_OCR = 5'h02,
      ST_SHC = 5'h04,
      ST_OVD = 5'h08,
      ST_STBY = 5'h10
   } dstate_t;
endpackage : prot_pkg

// ===== cell_env.sv
// Comparator front-end model that sets the cell condition levels.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Comparator model
// ****************************************
module cell_env
   import prot_pkg::*;
(
   input wire logic core_clk,
   input wire cmp_t want,
   output var logic ovc_cmp,
   output var logic ovd_cmp,
   output var logic ocr_cmp,
   output var logic shc_cmp,
   output var logic xch_cmp
);
   // Levels move one edge late, as a real comparator settles after the
   // cell state; the sync inside the block absorbs the phase.
   always @(posedge core_clk)
   begin
      {ovc_cmp, ovd_cmp, ocr_cmp, shc_cmp, xch_cmp} <= #1 want;
   end
endmodule : cell_env
`default_nettype wire

// ===== test_prot_overlap.sv
// Self-checking testbench of the protection overlap arbitration.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Testbench top
// ****************************************
module test_prot_overlap;
   import prot_pkg::*;
   localparam int US = CLK_HZ / 1_000_000;
   localparam int D_OVC = OVC_DLY_US * US / TEST_DIV;
   localparam int D_OVD = OVD_DLY_US * US / TEST_DIV;
   localparam int D_OCR = OCR_DLY_US * US / TEST_DIV;
   localparam int D_REL = OCR_REL_US * US / TEST_DIV;
   localparam int D_XCH = XCH_DLY_US * US / TEST_DIV;
   localparam int DIS = 4;
   localparam int CHG = 3;
   localparam int PDN = 2;
   localparam int PUP = 1;
   localparam int STB = 0;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic test_short = 1'b1;
   cmp_t want = '0;
   logic ovc_cmp, ovd_cmp, ocr_cmp, shc_cmp, xch_cmp;
   logic dis_gate, chg_gate, pull_dn, pull_up, standby;
   logic [4:0] o;
   int error_cnt = 0;
   int num_checks = 0;
   assign o = {dis_gate, chg_gate, pull_dn, pull_up, standby};
   always #20 core_clk = ~core_clk;
   cell_env env (.core_clk(core_clk), .want(want), .ovc_cmp(ovc_cmp),
      .ovd_cmp(ovd_cmp), .ocr_cmp(ocr_cmp), .shc_cmp(shc_cmp),
      .xch_cmp(xch_cmp));
   prot_overlap dut (.core_clk(core_clk), .rst(rst), .ovc_cmp(ovc_cmp),
      .ovd_cmp(ovd_cmp), .ocr_cmp(ocr_cmp), .shc_cmp(shc_cmp),
      .xch_cmp(xch_cmp), .test_short(test_short), .dis_gate(dis_gate),
      .chg_gate(chg_gate), .pull_dn(pull_dn), .pull_up(pull_up),
      .standby(standby));
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic chk(input int idx, input logic exp);
      num_checks++;
      if (o[idx] !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: output %0d is %b", $time, idx, o[idx]);
      end
   endtask : chk
   // A bounded wait; an early or a missing change counts as a mismatch.
   task automatic wait_o(input int idx, input logic v, input int lo,
      input int hi);
      int n;
      n = 0;
      while (o[idx] !== v && n <= hi)
      begin
         tick(1);
         n++;
      end
      num_checks++;
      if (n < lo || n > hi)
      begin
         error_cnt++;
         $display("Error at %0t: output %0d late or early, %0d", $time,
            idx, n);
      end
   endtask : wait_o
   task automatic restart;
      want = '0;
      rst = 1'b1;
      tick(5);
      rst = 1'b0;
      tick(1);
   endtask : restart
   task automatic t_ocr;
      restart();
      want.ocr = 1'b1;
      wait_o(DIS, 1'b0, D_OCR - 2, D_OCR + 12);
      chk(PDN, 1'b1);
      chk(STB, 1'b0);
      want.ovd = 1'b1;
      wait_o(STB, 1'b1, D_OVD - 2, D_OVD + 12);
      chk(PDN, 1'b0);
      chk(PUP, 1'b1);
      $display("t_ocr done");
   endtask : t_ocr
   task automatic t_ovc_ocr;
      restart();
      want.ocr = 1'b1;
      wait_o(DIS, 1'b0, D_OCR - 2, D_OCR + 12);
      want.ovc = 1'b1;
      wait_o(CHG, 1'b0, D_OVC - 2, D_OVC + 12);
      chk(PDN, 1'b1);
      restart();
      want.ovc = 1'b1;
      wait_o(CHG, 1'b0, D_OVC - 2, D_OVC + 12);
      want.ocr = 1'b1;
      tick(D_OCR + 100);
      chk(DIS, 1'b1);
      chk(PDN, 1'b0);
      chk(PUP, 1'b0);
      $display("t_ovc_ocr done");
   endtask : t_ovc_ocr
   task automatic t_ovd_ovc;
      restart();
      want.ovd = 1'b1;
      tick(D_OVD / 2);
      want.ovc = 1'b1;
      wait_o(CHG, 1'b0, D_OVC - 2, D_OVC + 12);
      wait_o(DIS, 1'b0, D_OVD - 20, D_OVD + 20);
      chk(PUP, 1'b1);
      chk(STB, 1'b0);
      $display("t_ovd_ovc done");
   endtask : t_ovd_ovc
   task automatic t_ovd;
      restart();
      want.ovd = 1'b1;
      wait_o(DIS, 1'b0, D_OVD - 2, D_OVD + 12);
      tick(2);
      chk(STB, 1'b1);
      chk(PUP, 1'b1);
      want.ocr = 1'b1;
      tick(D_OCR + 100);
      chk(PDN, 1'b0);
      $display("t_ovd done");
   endtask : t_ovd
   // The short-circuit figure ignores the test input on purpose.
   task automatic t_shc;
      restart();
      want.shc = 1'b1;
      wait_o(DIS, 1'b0, SHC_CYC - 2, SHC_CYC + 12);
      chk(PDN, 1'b1);
      // With the test input low the over-charge delay is the full one.
      test_short = 1'b0;
      restart();
      want.ovc = 1'b1;
      tick(D_OVC + 100);
      chk(CHG, 1'b1);
      test_short = 1'b1;
      $display("t_shc done");
   endtask : t_shc
   task automatic t_xch;
      restart();
      want.xch = 1'b1;
      tick(D_XCH / 2);
      want.xch = 1'b0;
      tick(D_XCH);
      chk(CHG, 1'b1);
      want.xch = 1'b1;
      wait_o(CHG, 1'b0, D_XCH - 2, D_XCH + 12);
      restart();
      want.ocr = 1'b1;
      wait_o(DIS, 1'b0, D_OCR - 2, D_OCR + 12);
      want.xch = 1'b1;
      tick(D_XCH + 100);
      chk(CHG, 1'b1);
      want.ocr = 1'b0;
      wait_o(DIS, 1'b1, D_REL - 2, D_REL + 12);
      wait_o(CHG, 1'b0, D_XCH - 2, D_XCH + 12);
      want.xch = 1'b0;
      wait_o(CHG, 1'b1, D_XCH - 2, D_XCH + 12);
      $display("t_xch done");
   endtask : t_xch
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      t_ocr();
      t_ovc_ocr();
      t_ovd_ovc();
      t_ovd();
      t_shc();
      t_xch();
      tally_and_finish();
   end
endmodule : test_prot_overlap
`default_nettype wire
